/* File: hdl/system_config_port_control.sv */
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module system_config_port_control import sys_config_pkg::*; #(
  // arbitrary identifier text, sixteen ascii characters
  parameter logic [127:0] CHIP_IDENTIFIER_VALUE = "CFGBLK-ID-000001"
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic rtcEvent,
  input wire logic externalPinIrq,
  input wire logic [GPIO_IRQ_N-1:0] gpioIrq,
  input wire logic sdmmcCtrlLowVolt,
  input wire logic i2cTwoReq,
  input wire logic sdmmcHostReq,
  input wire logic i2cThreeReq,
  input wire logic i2cFourReq,
  input wire logic cipherTxReq,
  input wire logic cipherRxReq,
  output logic [63:0] portBFunction,
  output logic [63:0] portCFunction,
  output logic portProtectOn,
  output logic rtcToWakeup,
  output logic rtcToNmi,
  output logic rtcToSysIrq,
  output logic timerOneTrigger,
  output logic timerTwoTrigger,
  output logic mainDomainLowVolt,
  output logic sdioDomainLowVolt,
  output logic sdmmcDomainLowVolt,
  output logic flashDomainLowVolt,
  output logic rtcDomainLowVolt,
  output logic fastOscRateSelect,
  output logic dmaReq9,
  output logic dmaReq10,
  output logic dmaReq11,
  output logic [15:0] portAPinHysteresis,
  output logic [15:0] portBPinHysteresis,
  output logic [15:0] portCPinHysteresis,
  output logic [5:0] portDPinHysteresis
);
  // byte-lane merge with reserved bits forced to zero
  function automatic logic [31:0] mergeBytes(input logic [31:0] oldWord,
                                             input logic [31:0] newWord,
                                             input logic [3:0] strb,
                                             input logic [31:0] mask);
    logic [31:0] res;
    res = oldWord;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = newWord[8*b +: 8];
      end
    end
    return res & mask;
  endfunction

  // word-index match against a byte offset
  function automatic logic hitWord(input logic [ADDR_W-1:0] addr,
                                   input logic [7:0] offset);
    return addr[ADDR_W-1:2] == offset[7:2];
  endfunction

  // write channel holding registers
  logic awHeld_reg, wHeld_reg, bvalid_reg;
  logic [ADDR_W-1:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  // read channel
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  // register bank
  logic [31:0] pbLo_reg, pbHi_reg, pcLo_reg, pcHi_reg;
  logic [31:0] route_reg, volt_reg, misc_reg, hystAb_reg, hystCd_reg;
  // registered outputs
  logic rtcWake_reg, rtcNmi_reg, rtcSys_reg;
  logic [TIMER_N-1:0] timerTrig_reg;
  logic sdmmcVolt_reg, dma9_reg, dma10_reg, dma11_reg;

  // lock engine status
  logic protectOn, lockOk;
  logic [LOCK_CODE_W-1:0] lockCode;

  // handshakes: one write and one read in flight, all frozen by ce
  assign awready = ce && !awHeld_reg && !bvalid_reg;
  assign wready = ce && !wHeld_reg && !bvalid_reg;
  assign arready = ce && !rvalid_reg;
  wire awTake = awvalid && awready;
  wire wTake = wvalid && wready;
  wire arTake = arvalid && arready;
  wire haveAw = awHeld_reg || awTake;
  wire haveW = wHeld_reg || wTake;
  wire doWrite = haveAw && haveW;
  wire [ADDR_W-1:0] wrAddr = awHeld_reg ? awAddr_reg : awaddr;
  wire [31:0] wrData = wHeld_reg ? wData_reg : wdata;
  wire [3:0] wrStrb = wHeld_reg ? wStrb_reg : wstrb;

  // write decode; port registers gated by protection
  wire portWritable = !protectOn;
  wire wrPbLo = doWrite && portWritable && hitWord(wrAddr, OFF_PB_FSEL_LO);
  wire wrPbHi = doWrite && portWritable && hitWord(wrAddr, OFF_PB_FSEL_HI);
  wire wrPcLo = doWrite && portWritable && hitWord(wrAddr, OFF_PC_FSEL_LO);
  wire wrPcHi = doWrite && portWritable && hitWord(wrAddr, OFF_PC_FSEL_HI);
  wire wrHystAb = doWrite && portWritable && hitWord(wrAddr, OFF_HYST_AB);
  wire wrHystCd = doWrite && portWritable && hitWord(wrAddr, OFF_HYST_CD);
  wire wrRoute = doWrite && hitWord(wrAddr, OFF_ROUTE);
  wire wrVolt = doWrite && hitWord(wrAddr, OFF_VOLT);
  wire wrMisc = doWrite && hitWord(wrAddr, OFF_MISC);
  // lock word counts only when all three low lanes are written
  wire wrLock = doWrite && hitWord(wrAddr, OFF_LOCK) && (&wrStrb[2:0]);

  // write channel state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      awAddr_reg <= '0;
      wData_reg <= '0;
      wStrb_reg <= '0;
    end else if (ce) begin
      if (awTake) awAddr_reg <= awaddr;
      if (wTake) begin
        wData_reg <= wdata;
        wStrb_reg <= wstrb;
      end
      awHeld_reg <= haveAw && !doWrite;
      wHeld_reg <= haveW && !doWrite;
      bvalid_reg <= doWrite || (bvalid_reg && !bready);
    end
  end

  // port B and C function selects, values 8 and above cannot be stored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pbLo_reg <= FSEL_RESET;
      pbHi_reg <= FSEL_RESET;
      pcLo_reg <= FSEL_RESET;
      pcHi_reg <= FSEL_RESET;
    end else if (ce) begin
      if (wrPbLo) pbLo_reg <= mergeBytes(pbLo_reg, wrData, wrStrb, FSEL_MASK);
      if (wrPbHi) pbHi_reg <= mergeBytes(pbHi_reg, wrData, wrStrb, FSEL_MASK);
      if (wrPcLo) pcLo_reg <= mergeBytes(pcLo_reg, wrData, wrStrb, FSEL_MASK);
      if (wrPcHi) pcHi_reg <= mergeBytes(pcHi_reg, wrData, wrStrb, FSEL_MASK);
    end
  end

  // hysteresis enables, all on after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hystAb_reg <= HYST_AB_RESET;
      hystCd_reg <= HYST_CD_RESET;
    end else if (ce) begin
      if (wrHystAb) hystAb_reg <= mergeBytes(hystAb_reg, wrData, wrStrb, HYST_AB_RESET);
      if (wrHystCd) hystCd_reg <= mergeBytes(hystCd_reg, wrData, wrStrb, HYST_CD_RESET);
    end
  end

  // routing, voltage and miscellaneous settings; reserved bits masked
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      route_reg <= ROUTE_RESET;
      volt_reg <= VOLT_RESET;
      misc_reg <= MISC_RESET;
    end else if (ce) begin
      if (wrRoute) route_reg <= mergeBytes(route_reg, wrData, wrStrb, ROUTE_MASK);
      if (wrVolt) volt_reg <= mergeBytes(volt_reg, wrData, wrStrb, VOLT_MASK);
      if (wrMisc) misc_reg <= mergeBytes(misc_reg, wrData, wrStrb, MISC_MASK);
    end
  end

  // keyed write-protection sequence
  port_lock_sequencer lock_u (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .wrStrobe(wrLock),
    .wrData(wrData),
    .protectOn(protectOn),
    .seqOk(lockOk),
    .codeHeld(lockCode)
  );

  // read decode; unmapped offsets and reserved bits read zero
  wire [31:0] lockWord = {15'h0000, lockOk, lockCode, protectOn};
  wire [31:0] voltWord = {volt_reg[31:3], sdmmcVolt_reg, volt_reg[1:0]};
  wire idHit = araddr[ADDR_W-1:4] == OFF_CHIP_IDENTIFIER[7:4];
  wire [31:0] idWord = CHIP_IDENTIFIER_VALUE[{araddr[3:2], 5'b00000} +: 32];
  wire [31:0] readWord =
    hitWord(araddr, OFF_PB_FSEL_LO) ? pbLo_reg :
    hitWord(araddr, OFF_PB_FSEL_HI) ? pbHi_reg :
    hitWord(araddr, OFF_PC_FSEL_LO) ? pcLo_reg :
    hitWord(araddr, OFF_PC_FSEL_HI) ? pcHi_reg :
    hitWord(araddr, OFF_LOCK) ? lockWord :
    hitWord(araddr, OFF_ROUTE) ? route_reg :
    hitWord(araddr, OFF_VOLT) ? voltWord :
    hitWord(araddr, OFF_MISC) ? misc_reg :
    hitWord(araddr, OFF_HYST_AB) ? hystAb_reg :
    hitWord(araddr, OFF_HYST_CD) ? hystCd_reg :
    idHit ? idWord : 32'h00000000;

  // read channel state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
    end else if (ce) begin
      if (arTake) rdata_reg <= readWord;
      rvalid_reg <= arTake || (rvalid_reg && !rready);
    end
  end

  // rtc event routing
  wire [1:0] rtcRoute = route_reg[RTC_ROUTE_LSB +: 2];
  wire rtcWakeNext = rtcEvent && (rtcRoute == RTC_TO_WAKEUP);
  wire rtcNmiNext = rtcEvent && (rtcRoute == RTC_TO_NMI);
  wire rtcSysNext = rtcEvent && (rtcRoute == RTC_TO_SYSIRQ);

  // timer triggers, second field directly above the first
  logic [TIMER_N-1:0] timerTrigNext;
  genvar t;
  generate
    for (t = 0; t < TIMER_N; t++) begin : g_timer
      trigger_route_decoder dec_u (
        .code(route_reg[TRIG_LSB + t*TRIG_W +: TRIG_W]),
        .externalPinIrq(externalPinIrq),
        .gpioIrq(gpioIrq),
        .trigger(timerTrigNext[t])
      );
    end
  endgenerate

  // voltage source and dma request selection
  wire swOwnsSdmmc = misc_reg[SDMMC_SRC_BIT];
  wire sdmmcVoltNext = swOwnsSdmmc ? volt_reg[VOLT_SDMMC_BIT] : sdmmcCtrlLowVolt;
  wire dma9Next = misc_reg[DMA9_SRC_BIT] ? sdmmcHostReq : i2cTwoReq;
  wire dma10Next = misc_reg[DMA1011_SRC_BIT] ? cipherTxReq : i2cThreeReq;
  wire dma11Next = misc_reg[DMA1011_SRC_BIT] ? cipherRxReq : i2cFourReq;

  // registered event and request outputs, one cycle behind their inputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rtcWake_reg <= 1'b0;
      rtcNmi_reg <= 1'b0;
      rtcSys_reg <= 1'b0;
      timerTrig_reg <= '0;
      sdmmcVolt_reg <= 1'b0;
      dma9_reg <= 1'b0;
      dma10_reg <= 1'b0;
      dma11_reg <= 1'b0;
    end else if (ce) begin
      rtcWake_reg <= rtcWakeNext;
      rtcNmi_reg <= rtcNmiNext;
      rtcSys_reg <= rtcSysNext;
      timerTrig_reg <= timerTrigNext;
      sdmmcVolt_reg <= sdmmcVoltNext;
      dma9_reg <= dma9Next;
      dma10_reg <= dma10Next;
      dma11_reg <= dma11Next;
    end
  end

  // bus outputs
  assign bvalid = bvalid_reg;
  assign bresp = RESP_OKAY;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = RESP_OKAY;

  // configuration outputs straight from the registers
  assign portBFunction = {pbHi_reg, pbLo_reg};
  assign portCFunction = {pcHi_reg, pcLo_reg};
  assign portProtectOn = protectOn;
  assign rtcToWakeup = rtcWake_reg;
  assign rtcToNmi = rtcNmi_reg;
  assign rtcToSysIrq = rtcSys_reg;
  assign timerOneTrigger = timerTrig_reg[0];
  assign timerTwoTrigger = timerTrig_reg[1];
  assign mainDomainLowVolt = volt_reg[0];
  assign sdioDomainLowVolt = volt_reg[1];
  assign sdmmcDomainLowVolt = sdmmcVolt_reg;
  assign flashDomainLowVolt = volt_reg[3];
  assign rtcDomainLowVolt = volt_reg[4];
  assign fastOscRateSelect = misc_reg[OSC_RATE_BIT];
  assign dmaReq9 = dma9_reg;
  assign dmaReq10 = dma10_reg;
  assign dmaReq11 = dma11_reg;
  assign portAPinHysteresis = hystAb_reg[15:0];
  assign portBPinHysteresis = hystAb_reg[31:16];
  assign portCPinHysteresis = hystCd_reg[15:0];
  assign portDPinHysteresis = hystCd_reg[21:16];
endmodule // system_config_port_control

/* File: hdl/sys_config_pkg.sv */
// How it works
// - port B and C each get low and high function select registers
// - four-bit field per pin, eight pins per word, only values 0 to 7 kept
// - lock word: enable bit 0, code bits 15:1, key bit 16
// - key bit reads one when the last lock sequence completed
// - committed protection blocks writes to port configuration registers
// - two-bit RTC route: off, standby wakeup, NMI, system interrupt
// - timer trigger code: 0 none, 1 external pin, 8 to 12 GPIO one to five
// - second timer field sits above the first and decodes identically
// - five domain voltage bits: zero means 3.3 V, one means 1.8 V
// - source bit gives SDMMC voltage select to controller (0) or software (1)
// - misc bit 0 selects fast oscillator 12 MHz (0) or 6 MHz (1)
// - DMA line 9 from second I2C (0) or SDMMC host (1)
// - DMA lines 10 and 11 from I2C three and four (0) or cipher tx/rx (1)
// - port A/B hysteresis enables, A low half, B high half, reset all ones
// - port C/D hysteresis: C in 15:0, D in 21:16, reset ones, rest reserved
// - read-only 128-bit ASCII chip identifier in the top sixteen bytes
package sys_config_pkg;
  localparam int ADDR_W = 8;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  // register byte offsets
  localparam logic [7:0] OFF_PB_FSEL_LO = 8'h88;
  localparam logic [7:0] OFF_PB_FSEL_HI = 8'h8C;
  localparam logic [7:0] OFF_PC_FSEL_LO = 8'h90;
  localparam logic [7:0] OFF_PC_FSEL_HI = 8'h94;
  localparam logic [7:0] OFF_LOCK = 8'hC0;
  localparam logic [7:0] OFF_ROUTE = 8'hC4;
  localparam logic [7:0] OFF_VOLT = 8'hD0;
  localparam logic [7:0] OFF_MISC = 8'hD8;
  localparam logic [7:0] OFF_HYST_AB = 8'hDC;
  localparam logic [7:0] OFF_HYST_CD = 8'hE0;
  localparam logic [7:0] OFF_CHIP_IDENTIFIER = 8'hF0;
  // function select fields
  localparam logic [31:0] FSEL_MASK = 32'h77777777;
  localparam logic [31:0] FSEL_RESET = 32'h00000000;
  // lock register fields
  localparam int LOCK_EN_BIT = 0;
  localparam int LOCK_CODE_LSB = 1;
  localparam int LOCK_CODE_W = 15;
  localparam int LOCK_KEY_BIT = 16;
  // event routing fields and codes
  localparam int RTC_ROUTE_LSB = 8;
  localparam int TRIG_LSB = 16;
  localparam int TRIG_W = 4;
  localparam int TIMER_N = 2;
  localparam int GPIO_IRQ_N = 5;
  localparam logic [31:0] ROUTE_MASK = 32'h00FF0300;
  localparam logic [31:0] ROUTE_RESET = 32'h00000000;
  localparam logic [1:0] RTC_TO_WAKEUP = 2'h1;
  localparam logic [1:0] RTC_TO_NMI = 2'h2;
  localparam logic [1:0] RTC_TO_SYSIRQ = 2'h3;
  localparam logic [3:0] TRIG_EXT_PIN = 4'h1;
  localparam logic [3:0] TRIG_GPIO_FIRST = 4'h8;
  // voltage select fields
  localparam int VOLT_SDMMC_BIT = 2;
  localparam logic [31:0] VOLT_MASK = 32'h0000001F;
  localparam logic [31:0] VOLT_RESET = 32'h00000000;
  // miscellaneous fields
  localparam int OSC_RATE_BIT = 0;
  localparam int DMA9_SRC_BIT = 1;
  localparam int DMA1011_SRC_BIT = 2;
  localparam int SDMMC_SRC_BIT = 3;
  localparam logic [31:0] MISC_MASK = 32'h0000000F;
  localparam logic [31:0] MISC_RESET = 32'h00000000;
  // hysteresis registers
  localparam logic [31:0] HYST_AB_RESET = 32'hFFFFFFFF;
  localparam logic [31:0] HYST_CD_RESET = 32'h003FFFFF;
  typedef enum logic [1:0] {LOCK_IDLE, LOCK_FIRST, LOCK_SECOND} lock_state_t;
endpackage

/* File: hdl/port_lock_sequencer.sv */
`timescale 1ns/1ps
module port_lock_sequencer import sys_config_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic wrStrobe,
  input wire logic [31:0] wrData,
  output logic protectOn,
  output logic seqOk,
  output logic [LOCK_CODE_W-1:0] codeHeld
);
  lock_state_t state_reg, state_next;
  logic enHeld_reg;
  logic [LOCK_CODE_W-1:0] code_reg;
  logic protect_reg, protect_next, ok_reg, ok_next;
  wire keyBit = wrData[LOCK_KEY_BIT];
  wire enBit = wrData[LOCK_EN_BIT];
  wire [LOCK_CODE_W-1:0] codeBits = wrData[LOCK_CODE_LSB +: LOCK_CODE_W];
  wire sameWord = (enBit == enHeld_reg) && (codeBits == code_reg);
  wire firstWrite = wrStrobe && keyBit && (state_reg != LOCK_SECOND || !sameWord);

  // three-write sequence; a key write in the second step restarts it, other mismatches drop back to idle with failure
  always_comb begin
    state_next = state_reg;
    protect_next = protect_reg;
    ok_next = ok_reg;
    if (wrStrobe) begin
      unique case (state_reg)
        LOCK_IDLE: begin
          if (keyBit) begin
            state_next = LOCK_FIRST;
            ok_next = 1'b0;
          end
        end
        LOCK_FIRST: begin
          if (!keyBit && sameWord) begin
            state_next = LOCK_SECOND;
          end else if (keyBit) begin
            state_next = LOCK_FIRST;
            ok_next = 1'b0;
          end else begin
            state_next = LOCK_IDLE;
            ok_next = 1'b0;
          end
        end
        LOCK_SECOND: begin
          if (keyBit && sameWord) begin
            state_next = LOCK_IDLE;
            protect_next = enHeld_reg;
            ok_next = 1'b1;
          end else begin
            state_next = LOCK_IDLE;
            ok_next = 1'b0;
          end
        end
      endcase
    end
  end

  // state and capture of the first write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= LOCK_IDLE;
      protect_reg <= 1'b0;
      ok_reg <= 1'b0;
      enHeld_reg <= 1'b0;
      code_reg <= '0;
    end else if (ce) begin
      state_reg <= state_next;
      protect_reg <= protect_next;
      ok_reg <= ok_next;
      if (firstWrite) begin
        enHeld_reg <= enBit;
        code_reg <= codeBits;
      end
    end
  end

  assign protectOn = protect_reg;
  assign seqOk = ok_reg;
  assign codeHeld = code_reg;
endmodule // port_lock_sequencer

/* File: hdl/trigger_route_decoder.sv */
`timescale 1ns/1ps
module trigger_route_decoder import sys_config_pkg::*; (
  input wire logic [TRIG_W-1:0] code,
  input wire logic externalPinIrq,
  input wire logic [GPIO_IRQ_N-1:0] gpioIrq,
  output logic trigger
);
  wire [TRIG_W-1:0] gpioIdx = code - TRIG_GPIO_FIRST;
  wire isExt = (code == TRIG_EXT_PIN);
  wire isGpio = (code >= TRIG_GPIO_FIRST) && (gpioIdx < TRIG_W'(GPIO_IRQ_N));
  wire [2:0] gpioSel = gpioIdx[2:0];

  // none, external pin, or one of the gpio lines; reserved codes give nothing
  assign trigger = (isExt && externalPinIrq) || (isGpio && gpioIrq[gpioSel]);
endmodule // trigger_route_decoder

/* File: verification/system_config_port_control_sva.sv */
`timescale 1ns/1ps
module system_config_port_control_sva import sys_config_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic awready,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rtcEvent,
  input wire logic rtcToWakeup,
  input wire logic rtcToNmi,
  input wire logic rtcToSysIrq,
  input wire logic externalPinIrq,
  input wire logic [GPIO_IRQ_N-1:0] gpioIrq,
  input wire logic timerOneTrigger,
  input wire logic i2cTwoReq,
  input wire logic sdmmcHostReq,
  input wire logic dmaReq9,
  input wire logic i2cThreeReq,
  input wire logic cipherTxReq,
  input wire logic dmaReq10,
  input wire logic portProtectOn,
  input wire logic [63:0] portBFunction,
  input wire logic [15:0] portAPinHysteresis
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // bus answer timing and codes
  chk_read_latency: assert property (arvalid && arready |=> rvalid)
    else $error("read answer not one cycle after address");
  chk_read_cause: assert property (rvalid && !$past(rvalid) |-> $past(arvalid && arready))
    else $error("read answer without request");
  chk_write_okay: assert property (bvalid |-> bresp == RESP_OKAY)
    else $error("write response not okay");
  chk_ready_ce: assert property (!ce |-> !awready && !wready && !arready)
    else $error("ready while clock enable low");
  // event routing
  chk_rtc_cause: assert property ((rtcToWakeup || rtcToNmi || rtcToSysIrq) |-> $past(rtcEvent))
    else $error("rtc route without event");
  chk_rtc_onehot: assert property ($onehot0({rtcToWakeup, rtcToNmi, rtcToSysIrq}))
    else $error("rtc routed to several places");
  chk_timer_cause: assert property (timerOneTrigger |-> $past(externalPinIrq || (|gpioIrq)))
    else $error("timer trigger without source");
  // dma muxing
  chk_dma9_source: assert property (dmaReq9 |-> $past(i2cTwoReq || sdmmcHostReq))
    else $error("dma line 9 without source");
  chk_dma10_source: assert property (dmaReq10 |-> $past(i2cThreeReq || cipherTxReq))
    else $error("dma line 10 without source");
  // protection freezes port registers
  chk_lock_blocks: assert property (portProtectOn |=> $stable(portBFunction)
    && $stable(portAPinHysteresis)) else $error("port register changed while locked");
endmodule // system_config_port_control_sva

/* File: verification/system_config_port_control_test.sv */
`timescale 1ns/1ps
module system_config_port_control_test;
  import sys_config_pkg::*;
  // arbitrary identifier text
  localparam logic [127:0] ID_TEXT = "TB-IDENT-ABCD-07";
  logic clk, rst_n, ce, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, rtcEvent, externalPinIrq, sdmmcCtrlLowVolt;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [3:0] wstrb;
  logic [4:0] gpioIrq;
  logic i2cTwoReq, sdmmcHostReq, i2cThreeReq, i2cFourReq, cipherTxReq, cipherRxReq;
  logic [63:0] portBFunction, portCFunction;
  logic portProtectOn, rtcToWakeup, rtcToNmi, rtcToSysIrq, timerOneTrigger, timerTwoTrigger;
  logic mainDomainLowVolt, sdioDomainLowVolt, sdmmcDomainLowVolt, flashDomainLowVolt;
  logic rtcDomainLowVolt, fastOscRateSelect, dmaReq9, dmaReq10, dmaReq11;
  logic [15:0] portAPinHysteresis, portBPinHysteresis, portCPinHysteresis;
  logic [5:0] portDPinHysteresis;
  int error_cnt = 0;
  int checks = 0;
  system_config_port_control #(.CHIP_IDENTIFIER_VALUE(ID_TEXT)) dut_u (.clk, .rst_n, .ce, .awaddr,
    .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .rtcEvent, .externalPinIrq, .gpioIrq, .sdmmcCtrlLowVolt, .i2cTwoReq, .sdmmcHostReq,
    .i2cThreeReq, .i2cFourReq, .cipherTxReq, .cipherRxReq, .portBFunction, .portCFunction,
    .portProtectOn, .rtcToWakeup, .rtcToNmi, .rtcToSysIrq, .timerOneTrigger, .timerTwoTrigger,
    .mainDomainLowVolt, .sdioDomainLowVolt, .sdmmcDomainLowVolt, .flashDomainLowVolt,
    .rtcDomainLowVolt, .fastOscRateSelect, .dmaReq9, .dmaReq10, .dmaReq11, .portAPinHysteresis,
    .portBPinHysteresis, .portCPinHysteresis, .portDPinHysteresis);
  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one write, each channel released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit aDone = 0;
    bit wDone = 0;
    bit got = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got) begin
      @(posedge clk);
      if (!aDone && awready) begin
        aDone = 1;
        awvalid <= 1'b0;
      end
      if (!wDone && wready) begin
        wDone = 1;
        wvalid <= 1'b0;
      end
      if (bvalid) begin
        got = 1;
        bready <= 1'b0;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bit aDone = 0;
    bit got = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got) begin
      @(posedge clk);
      if (!aDone && arready) begin
        aDone = 1;
        arvalid <= 1'b0;
      end
      if (rvalid) begin
        got = 1;
        d = rdata;
        rready <= 1'b0;
      end
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp);
  endtask
  task automatic lock_seq(input logic en, input logic [14:0] c1, c2, c3);
    wr(OFF_LOCK, {15'h0, 1'b1, c1, en});
    wr(OFF_LOCK, {15'h0, 1'b0, c2, en});
    wr(OFF_LOCK, {15'h0, 1'b1, c3, en});
  endtask
  function automatic logic trig(input logic [3:0] c, input int s);
    return (s == 0) ? (c == 4'h1) : (c == 4'h7 + 4'(s));
  endfunction
  task automatic test_reset;
    @(posedge clk);
    ce <= 1'b0;
    repeat (2) @(posedge clk);
    chk({awready, wready, arready}, 32'h0);
    ce <= 1'b1;
    rdchk(OFF_HYST_AB, 32'hFFFFFFFF);
    rdchk(OFF_HYST_CD, 32'h003FFFFF);
    chk({portBPinHysteresis, portAPinHysteresis}, 32'hFFFFFFFF);
    chk({portDPinHysteresis, portCPinHysteresis}, 32'h003FFFFF);
    rdchk(OFF_LOCK, 32'h0);
  endtask
  task automatic test_fsel_lock;
    wr(OFF_PB_FSEL_LO, 32'hFEDCBA98);
    wr(OFF_PB_FSEL_HI, 32'h9ABCDEF0);
    wr(OFF_PC_FSEL_LO, 32'h9ABCDEF0);
    wr(OFF_PC_FSEL_HI, 32'hFEDCBA98);
    rdchk(OFF_PB_FSEL_LO, 32'h76543210);
    rdchk(OFF_PC_FSEL_HI, 32'h76543210);
    chk(portBFunction[63:32], 32'h12345670);
    chk(portCFunction[31:0], 32'h12345670);
    lock_seq(1'b1, 15'h2A5B, 15'h2A5B, 15'h2A5B);
    rdchk(OFF_LOCK, {15'h0, 1'b1, 15'h2A5B, 1'b1});
    chk(portProtectOn, 32'h1);
    wr(OFF_PB_FSEL_LO, 32'h0);
    wr(OFF_HYST_CD, 32'h0);
    rdchk(OFF_PB_FSEL_LO, 32'h76543210);
    rdchk(OFF_HYST_CD, 32'h003FFFFF);
    lock_seq(1'b0, 15'h0011, 15'h0010, 15'h0011);
    rdchk(OFF_LOCK, {15'h0, 1'b0, 15'h0011, 1'b1});
    lock_seq(1'b0, 15'h0011, 15'h0011, 15'h0013);
    chk(portProtectOn, 32'h1);
    lock_seq(1'b0, 15'h7FFF, 15'h7FFF, 15'h7FFF);
    rdchk(OFF_LOCK, {15'h0, 1'b1, 15'h7FFF, 1'b0});
    wr(OFF_HYST_CD, 32'hFFC00005);
    rdchk(OFF_HYST_CD, 32'h00000005);
    // single byte lane: merges into hysteresis, lock word ignored
    wstrb <= 4'h1;
    wr(OFF_HYST_CD, 32'hFFFFFFFF);
    wr(OFF_LOCK, {15'h0, 1'b1, 15'h0001, 1'b1});
    wstrb <= 4'hF;
    rdchk(OFF_HYST_CD, 32'h000000FF);
    rdchk(OFF_LOCK, {15'h0, 1'b1, 15'h7FFF, 1'b0});
  endtask
  task automatic test_route;
    logic [3:0] codes[9] = '{4'h0, 4'h1, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD};
    for (int r = 0; r < 4; r++) begin
      wr(OFF_ROUTE, 32'hFFFF00FF | (32'(r) << 8));
      rdchk(OFF_ROUTE, 32'h00FF0000 | (32'(r) << 8));
      @(posedge clk);
      rtcEvent <= 1'b1;
      repeat (2) @(posedge clk);
      chk({rtcToWakeup, rtcToNmi, rtcToSysIrq}, {r == 1, r == 2, r == 3});
      rtcEvent <= 1'b0;
    end
    for (int i = 0; i < 9; i++) begin
      wr(OFF_ROUTE, {8'h0, codes[8-i], codes[i], 16'h0});
      for (int s = 0; s < 6; s++) begin
        @(posedge clk);
        externalPinIrq <= (s == 0);
        gpioIrq <= (s == 0) ? 5'h0 : 5'(1 << (s - 1));
        repeat (2) @(posedge clk);
        chk({timerTwoTrigger, timerOneTrigger}, {trig(codes[8-i], s), trig(codes[i], s)});
      end
    end
  endtask
  task automatic test_volt_misc;
    @(posedge clk);
    {i2cTwoReq, sdmmcHostReq, i2cThreeReq, cipherTxReq, i2cFourReq, cipherRxReq} <= 6'b101001;
    wr(OFF_MISC, 32'hFFFFFFFF);
    rdchk(OFF_MISC, 32'h0000000F);
    wr(OFF_VOLT, 32'hFFFFFFFF);
    repeat (2) @(posedge clk);
    rdchk(OFF_VOLT, 32'h0000001F);
    chk({mainDomainLowVolt, sdioDomainLowVolt, sdmmcDomainLowVolt, flashDomainLowVolt,
      rtcDomainLowVolt, fastOscRateSelect}, 32'h3F);
    chk({dmaReq9, dmaReq10, dmaReq11}, 32'h1);
    wr(OFF_MISC, 32'h0);
    repeat (2) @(posedge clk);
    chk({sdmmcDomainLowVolt, fastOscRateSelect, dmaReq9, dmaReq10, dmaReq11}, 32'h06);
    sdmmcCtrlLowVolt <= 1'b1;
    repeat (2) @(posedge clk);
    chk(sdmmcDomainLowVolt, 32'h1);
  endtask
  task automatic test_chip_identifier;
    for (int i = 0; i < 4; i++) begin
      rdchk(OFF_CHIP_IDENTIFIER + 8'(4 * i), ID_TEXT[32*i +: 32]);
    end
    wr(OFF_CHIP_IDENTIFIER, 32'h0);
    rdchk(OFF_CHIP_IDENTIFIER, ID_TEXT[31:0]);
    rdchk(8'hA0, 32'h0);
    chk(rresp, 32'h0);
    rdchk(8'hD4, 32'h0);
  endtask
  task automatic final_report;
    if (error_cnt == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, rtcEvent, externalPinIrq} = '0;
    {sdmmcCtrlLowVolt, i2cTwoReq, sdmmcHostReq, i2cThreeReq, i2cFourReq} = '0;
    {cipherTxReq, cipherRxReq, awaddr, araddr, wdata, gpioIrq} = '0;
    {ce, wstrb} = 5'h1F;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    test_reset();
    test_fsel_lock();
    test_route();
    test_volt_misc();
    test_chip_identifier();
    final_report();
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    final_report();
  end
endmodule // system_config_port_control_test
bind system_config_port_control system_config_port_control_sva chk_u (.clk, .rst_n, .ce,
  .awready, .wready, .bvalid, .bresp, .arvalid, .arready, .rvalid, .rtcEvent, .rtcToWakeup,
  .rtcToNmi, .rtcToSysIrq, .externalPinIrq, .gpioIrq, .timerOneTrigger, .i2cTwoReq,
  .sdmmcHostReq, .dmaReq9, .i2cThreeReq, .cipherTxReq, .dmaReq10, .portProtectOn,
  .portBFunction, .portAPinHysteresis);
